/* gpt_timer_pair.v */
// general-purpose timer pair with 16/32-bit modes, ahb-lite register slave
//
// What this block does
// - 32-bit match compares all 32 bits
// - edge-time rollover never raises dma request
// - no extra dma at lower-half boundary
// - edge-count prescaler extends counter, readable 23:16
// - adc trigger on match only when enabled
// - chaining trigger on match only when enabled
// - chaining trigger also needs output trigger enable
// - pwm raises periodic events, each maskable
// - value write loads counter in both directions
// - prescaler extends up count in periodic/snapshot
// - joined snapshot stores full 32 bits
//
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
`include "gpt_defines.vh"
`default_nettype none
module gpt_timer_pair (
  input wire i_mclk,
  input wire i_reset,
  input wire i_hsel,
  input wire [31:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire [2:0] i_hsize,
  input wire [31:0] i_hwdata,
  input wire i_hready,
  output reg [31:0] o_hrdata,
  output reg o_hreadyout,
  output reg o_hresp,
  input wire i_ccp_a,
  input wire i_ccp_b,
  output reg o_irq,
  output reg o_dma_req_a,
  output reg o_dma_req_b,
  output reg o_adc_trig_a,
  output reg o_adc_trig_b,
  output reg o_wot_trig_a,
  output reg o_wot_trig_b,
  output reg o_pwm_a,
  output reg o_pwm_b
);
  reg join_q;
  reg [2*`GPT_MODE_W-1:0] mode_q;
  reg [15:0] ctl_q;
  reg [31:0] load_q;
  reg [31:0] match_q;
  reg [15:0] pre_q;
  reg [`GPT_ST_W-1:0] imr_q;
  reg [`GPT_ST_W-1:0] ris_q;
  reg wr_pend_q;
  reg [7:0] wr_addr_q;
  wire [31:0] cnt_rd_a;
  wire [31:0] cnt_rd_b;
  wire [1:0] ev_tout;
  wire [1:0] ev_cap;
  wire [1:0] ev_match;
  wire [1:0] ev_dma;
  wire [1:0] pwm_lvl;
  wire [1:0] oneshot_done;
  wire addr_ok = i_hsel & i_htrans[1] & i_hready;
  wire wr_en = wr_pend_q;
  reg [1:0] sync1_q;
  reg [1:0] sync2_q;
  reg [1:0] ccp_prev_q;
  wire [1:0] ccp_edge = sync2_q & ~ccp_prev_q;

  // capture pins pass two flip-flops before edge detection
  always @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      sync1_q <= 2'h0;
      sync2_q <= 2'h0;
      ccp_prev_q <= 2'h0;
    end else begin
      sync1_q <= {i_ccp_b, i_ccp_a};
      sync2_q <= sync1_q;
      ccp_prev_q <= sync2_q;
    end
  end

  genvar h;
  generate
    for (h = 0; h < 2; h = h + 1) begin : g_half
      reg [31:0] cnt_q;
      reg [31:0] snap_q;
      reg [31:0] nxt;
      wire [`GPT_MODE_W-1:0] md = mode_q[h*`GPT_MODE_W +: `GPT_MODE_W];
      wire [2:0] sel = md[`GPT_MD_SEL];
      wire up = md[`GPT_MD_UP];
      wire wide = (h == 0) & join_q;
      wire en = ctl_q[h*`GPT_CTL_B + `GPT_CTL_EN] & ~((h == 1) & join_q);
      wire ote = ctl_q[h*`GPT_CTL_B + `GPT_CTL_OTE];
      wire [31:0] msk = wide ? 32'hffffffff : 32'h00ffffff;
      // prescaler forms bits 23:16 of the 24-bit count
      wire [31:0] lim = wide ? load_q : {8'h00, pre_q[h*8 +: 8], load_q[h*16 +: 16]};
      wire [31:0] mval = wide ? match_q : {16'h0000, match_q[h*16 +: 16]};
      wire [31:0] vwr = wide ? i_hwdata : {8'h00, pre_q[h*8 +: 8], i_hwdata[15:0]};
      wire vsel = wr_en & (wr_addr_q == (h == 0 ? `GPT_OFF_VALUE_A : `GPT_OFF_VALUE_B));
      wire edge_in = ccp_edge[h];
      wire edge_mode = (sel == `GPT_M_EDGE_CNT) | (sel == `GPT_M_EDGE_TIME);
      wire step = en & ((sel == `GPT_M_EDGE_CNT) ? edge_in : 1'b1);
      wire term = up & (sel != `GPT_M_EDGE_CNT) ? (cnt_q == lim) : (cnt_q == 32'h00000000);
      wire snap_ok = wide ? (md[`GPT_MD_SNAP_A] & md[`GPT_MD_SNAP_B]) : md[`GPT_MD_SNAP_A];
      always @* begin
        nxt = cnt_q;
        if (step) begin
          if (term) begin
            nxt = (up & (sel != `GPT_M_EDGE_CNT)) ? 32'h00000000 : lim;
          end else if (up & (sel != `GPT_M_EDGE_CNT)) begin
            nxt = (cnt_q + 32'h00000001) & msk;
          end else begin
            nxt = (cnt_q - 32'h00000001) & msk;
          end
        end
      end
      always @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
          cnt_q <= `GPT_RST_WORD;
          snap_q <= `GPT_RST_WORD;
        end else begin
          if (vsel) begin
            cnt_q <= vwr & msk;
          end else if (en & (sel == `GPT_M_EDGE_CNT) & edge_in & (cnt_q == mval)) begin
            cnt_q <= lim;
          end else begin
            cnt_q <= nxt;
          end
          if (en & edge_in & ((sel == `GPT_M_EDGE_TIME) | ((sel == `GPT_M_SNAPSHOT) & snap_ok))) begin
            snap_q <= cnt_q & (wide ? (snap_ok ? 32'hffffffff : 32'h0000ffff) : 32'h00ffffff);
          end
        end
      end
      // timeout fires only at the full-width terminal, never at 16'hffff of a joined count
      assign ev_tout[h] = step & term & ~edge_mode;
      assign ev_cap[h] = en & edge_in & ((sel == `GPT_M_EDGE_TIME) | (sel == `GPT_M_SNAPSHOT));
      assign ev_match[h] = en & (cnt_q == mval) & (sel != `GPT_M_EDGE_TIME) & (vsel == 1'b0);
      // rollover in edge-time mode is no dma source; only the captured edge is
      assign ev_dma[h] = (sel == `GPT_M_EDGE_TIME) ? ev_cap[h] :
        ((ev_tout[h] & md[`GPT_MD_DMA_EN]) | (ev_match[h] & md[`GPT_MD_MATCH_IE]) | ev_cap[h]);
      assign pwm_lvl[h] = en & (sel == `GPT_M_PWM) & ((cnt_q & msk) > mval);
      assign oneshot_done[h] = ev_tout[h] & (sel == `GPT_M_ONESHOT);
      wire use_snap = (sel == `GPT_M_EDGE_TIME) | ((sel == `GPT_M_SNAPSHOT) & snap_ok);
      if (h == 0) begin : g_rd
        assign cnt_rd_a = use_snap ? snap_q : (wide ? cnt_q : {8'h00, cnt_q[23:0]});
      end else begin : g_rd
        assign cnt_rd_b = join_q ? {16'h0000, g_half[0].cnt_q[31:16]} : (use_snap ? snap_q : {8'h00, cnt_q[23:0]});
      end
    end
  endgenerate

  // event flags in bit order timeout, capture, match per half
  wire [`GPT_ST_W-1:0] ev_all = {ev_match[1] & mode_q[`GPT_MODE_W + `GPT_MD_MATCH_IE], ev_cap[1], ev_tout[1],
    ev_match[0] & mode_q[`GPT_MD_MATCH_IE], ev_cap[0], ev_tout[0]};
  wire ris_clr = wr_en & (wr_addr_q == `GPT_OFF_RIS);

  always @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      join_q <= 1'b0;
      mode_q <= {2*`GPT_MODE_W{1'b0}};
      ctl_q <= 16'h0000;
      load_q <= {`GPT_RST_LOAD, `GPT_RST_LOAD};
      match_q <= `GPT_RST_WORD;
      pre_q <= 16'h0000;
      imr_q <= {`GPT_ST_W{1'b0}};
      ris_q <= {`GPT_ST_W{1'b0}};
    end else begin
      // set wins over a write-one-to-clear in the same cycle
      ris_q <= (ris_q & ~(ris_clr ? i_hwdata[`GPT_ST_W-1:0] : {`GPT_ST_W{1'b0}})) | ev_all;
      if (wr_en) begin
        case (wr_addr_q)
          `GPT_OFF_CFG: join_q <= i_hwdata[0];
          `GPT_OFF_MODE_A: mode_q[`GPT_MODE_W-1:0] <= i_hwdata[`GPT_MODE_W-1:0];
          `GPT_OFF_MODE_B: mode_q[2*`GPT_MODE_W-1:`GPT_MODE_W] <= i_hwdata[`GPT_MODE_W-1:0];
          `GPT_OFF_CTL: ctl_q <= i_hwdata[15:0];
          `GPT_OFF_LOAD_A: begin
            if (join_q) begin
              load_q <= i_hwdata;
            end else begin
              load_q[15:0] <= i_hwdata[15:0];
            end
          end
          `GPT_OFF_LOAD_B: load_q[31:16] <= i_hwdata[15:0];
          `GPT_OFF_MATCH_A: begin
            if (join_q) begin
              match_q <= i_hwdata;
            end else begin
              match_q[15:0] <= i_hwdata[15:0];
            end
          end
          `GPT_OFF_MATCH_B: match_q[31:16] <= i_hwdata[15:0];
          `GPT_OFF_PRE_A: pre_q[7:0] <= i_hwdata[7:0];
          `GPT_OFF_PRE_B: pre_q[15:8] <= i_hwdata[7:0];
          `GPT_OFF_IMR: imr_q <= i_hwdata[`GPT_ST_W-1:0];
          default: ;
        endcase
      end
      // one-shot stops itself at its terminal count
      if (oneshot_done[0]) begin
        ctl_q[`GPT_CTL_EN] <= 1'b0;
      end
      if (oneshot_done[1]) begin
        ctl_q[`GPT_CTL_B + `GPT_CTL_EN] <= 1'b0;
      end
    end
  end

  reg [31:0] rd_mux;
  always @* begin
    case (i_haddr[7:0])
      `GPT_OFF_CFG: rd_mux = {31'h00000000, join_q};
      `GPT_OFF_MODE_A: rd_mux = {23'h000000, mode_q[`GPT_MODE_W-1:0]};
      `GPT_OFF_MODE_B: rd_mux = {23'h000000, mode_q[2*`GPT_MODE_W-1:`GPT_MODE_W]};
      `GPT_OFF_CTL: rd_mux = {16'h0000, ctl_q};
      `GPT_OFF_LOAD_A: rd_mux = join_q ? load_q : {16'h0000, load_q[15:0]};
      `GPT_OFF_LOAD_B: rd_mux = {16'h0000, load_q[31:16]};
      `GPT_OFF_MATCH_A: rd_mux = join_q ? match_q : {16'h0000, match_q[15:0]};
      `GPT_OFF_MATCH_B: rd_mux = {16'h0000, match_q[31:16]};
      `GPT_OFF_PRE_A: rd_mux = {24'h000000, pre_q[7:0]};
      `GPT_OFF_PRE_B: rd_mux = {24'h000000, pre_q[15:8]};
      `GPT_OFF_VALUE_A: rd_mux = join_q ? g_half[0].cnt_q : {8'h00, g_half[0].cnt_q[23:0]};
      `GPT_OFF_VALUE_B: rd_mux = {8'h00, g_half[1].cnt_q[23:0]};
      `GPT_OFF_COUNT_A: rd_mux = cnt_rd_a;
      `GPT_OFF_COUNT_B: rd_mux = cnt_rd_b;
      `GPT_OFF_IMR: rd_mux = {26'h0000000, imr_q};
      `GPT_OFF_RIS: rd_mux = {26'h0000000, ris_q};
      `GPT_OFF_MIS: rd_mux = {26'h0000000, ris_q & imr_q};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // zero-wait slave: address captured, write done in data phase, read data registered
  always @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      o_hrdata <= 32'h00000000;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end else begin
      wr_pend_q <= addr_ok & i_hwrite;
      wr_addr_q <= i_haddr[7:0];
      if (addr_ok & ~i_hwrite) begin
        o_hrdata <= rd_mux;
      end
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end
  end

  always @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_irq <= 1'b0;
      o_dma_req_a <= 1'b0;
      o_dma_req_b <= 1'b0;
      o_adc_trig_a <= 1'b0;
      o_adc_trig_b <= 1'b0;
      o_wot_trig_a <= 1'b0;
      o_wot_trig_b <= 1'b0;
      o_pwm_a <= 1'b0;
      o_pwm_b <= 1'b0;
    end else begin
      o_irq <= |(((ris_q & ~(ris_clr ? i_hwdata[`GPT_ST_W-1:0] : {`GPT_ST_W{1'b0}})) | ev_all) & imr_q);
      o_dma_req_a <= ev_dma[0];
      o_dma_req_b <= ev_dma[1];
      o_adc_trig_a <= ev_match[0] & ctl_q[`GPT_CTL_OTE];
      o_adc_trig_b <= ev_match[1] & ctl_q[`GPT_CTL_B + `GPT_CTL_OTE];
      o_wot_trig_a <= ev_match[0] & ctl_q[`GPT_CTL_OTE] & mode_q[`GPT_MD_WOT];
      o_wot_trig_b <= ev_match[1] & ctl_q[`GPT_CTL_B + `GPT_CTL_OTE] & mode_q[`GPT_MODE_W + `GPT_MD_WOT];
      o_pwm_a <= pwm_lvl[0];
      o_pwm_b <= pwm_lvl[1];
    end
  end
endmodule // gpt_timer_pair
`default_nettype wire

/* gpt_defines.vh */
// register map, field positions, mode codes and reset values of the timer pair
`ifndef GPT_DEFINES_VH
`define GPT_DEFINES_VH
`define GPT_OFF_CFG 8'h00
`define GPT_OFF_MODE_A 8'h04
`define GPT_OFF_MODE_B 8'h08
`define GPT_OFF_CTL 8'h0c
`define GPT_OFF_LOAD_A 8'h10
`define GPT_OFF_LOAD_B 8'h14
`define GPT_OFF_MATCH_A 8'h18
`define GPT_OFF_MATCH_B 8'h1c
`define GPT_OFF_PRE_A 8'h20
`define GPT_OFF_PRE_B 8'h24
`define GPT_OFF_VALUE_A 8'h28
`define GPT_OFF_VALUE_B 8'h2c
`define GPT_OFF_COUNT_A 8'h30
`define GPT_OFF_COUNT_B 8'h34
`define GPT_OFF_IMR 8'h38
`define GPT_OFF_RIS 8'h3c
`define GPT_OFF_MIS 8'h40
// mode register fields
`define GPT_MODE_W 9
`define GPT_MD_SEL 2:0
`define GPT_MD_UP 3
`define GPT_MD_WOT 4
`define GPT_MD_SNAP_A 5
`define GPT_MD_SNAP_B 6
`define GPT_MD_MATCH_IE 7
`define GPT_MD_DMA_EN 8
// mode codes
`define GPT_M_ONESHOT 3'h0
`define GPT_M_PERIODIC 3'h1
`define GPT_M_SNAPSHOT 3'h2
`define GPT_M_EDGE_CNT 3'h3
`define GPT_M_EDGE_TIME 3'h4
`define GPT_M_PWM 3'h5
// control register fields, half b at bit +8
`define GPT_CTL_EN 0
`define GPT_CTL_OTE 1
`define GPT_CTL_B 8
// status bits per half: timeout, capture, match; half b at +3
`define GPT_ST_TOUT 0
`define GPT_ST_CAP 1
`define GPT_ST_MATCH 2
`define GPT_ST_W 6
// reset values
`define GPT_RST_LOAD 16'hffff
`define GPT_RST_WORD 32'h00000000
`endif

/* gpt_far_side.sv */
// far-side model: dma and adc trigger inputs as pulse counters, capture pin source
`default_nettype none
module gpt_far_side (
  input wire logic i_mclk,
  input wire logic i_dma_a,
  input wire logic i_adc_a,
  input wire logic i_adc_b,
  input wire logic i_wot_a,
  input wire logic i_wot_b,
  output logic o_ccp_a,
  output logic [31:0] o_dma_n,
  output logic [31:0] o_adc_n,
  output logic [31:0] o_wot_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_ccp_a = 1'b0;
    o_dma_n = 32'h0;
    o_adc_n = 32'h0;
    o_wot_n = 32'h0;
  end
  always @(posedge i_mclk) begin
    o_dma_n <= o_dma_n + {31'h0, i_dma_a};
    o_adc_n <= o_adc_n + {31'h0, i_adc_a} + {31'h0, i_adc_b};
    o_wot_n <= o_wot_n + {31'h0, i_wot_a} + {31'h0, i_wot_b};
  end
  // one clean rising edge, long enough for the pin synchroniser
  task pulse;
    o_ccp_a <= 1'b1;
    repeat (4) @(posedge i_mclk);
    o_ccp_a <= 1'b0;
    repeat (4) @(posedge i_mclk);
  endtask
endmodule // gpt_far_side
`default_nettype wire

/* gpt_timer_pair_properties.sv */
// port-level assertions of the timer pair
`default_nettype none
module gpt_timer_pair_properties (
  input wire i_mclk,
  input wire i_reset,
  input wire i_hsel,
  input wire [31:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire [31:0] i_hwdata,
  input wire i_hready,
  input wire [31:0] o_hrdata,
  input wire o_hreadyout,
  input wire o_hresp,
  input wire o_adc_trig_a,
  input wire o_adc_trig_b,
  input wire o_wot_trig_a,
  input wire o_wot_trig_b,
  input wire o_dma_req_b
);
  // shadow of control, chain bits and join bit as written by software
  logic [7:0] wa_q;
  logic [18:0] sh_q;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  always @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      wa_q <= 8'h01;
      sh_q <= 19'h0;
    end else begin
      wa_q <= (i_hsel && i_htrans[1] && i_hready && i_hwrite) ? i_haddr[7:0] : 8'h01;
      if (wa_q == 8'h0c) sh_q[15:0] <= i_hwdata[15:0];
      if (wa_q == 8'h04) sh_q[16] <= i_hwdata[4];
      if (wa_q == 8'h08) sh_q[17] <= i_hwdata[4];
      if (wa_q == 8'h00) sh_q[18] <= i_hwdata[0];
    end
  end
  a_resp_okay: assert property (!o_hresp) else $error("bad response");
  a_ready_high: assert property (o_hreadyout) else $error("wait state");
  a_rdata_hold: assert property (!$past(i_hsel && i_htrans[1] && i_hready && !i_hwrite) |-> $stable(o_hrdata))
    else $error("read data moved");
  a_adc_a_en: assert property (o_adc_trig_a |-> $past(sh_q[1:0]) == 2'b11) else $error("adc a off");
  a_adc_b_en: assert property (o_adc_trig_b |-> $past(sh_q[9:8]) == 2'b11 && !$past(sh_q[18]))
    else $error("adc b off");
  a_wot_a_ote: assert property (o_wot_trig_a |-> o_adc_trig_a && $past(sh_q[16])) else $error("chain a");
  a_wot_b_ote: assert property (o_wot_trig_b |-> o_adc_trig_b && $past(sh_q[17])) else $error("chain b");
  a_b_inert: assert property ($past(sh_q[18]) |-> !o_dma_req_b && !o_adc_trig_b) else $error("b active");
  c_wot_a: cover property (o_wot_trig_a);
  c_wot_b: cover property (o_wot_trig_b);
  c_joined: cover property (sh_q[18] && sh_q[0]);
endmodule // gpt_timer_pair_properties
bind gpt_timer_pair gpt_timer_pair_properties i_props (.*);
`default_nettype wire

/* test_gpt_timer_pair.sv */
// self-checking bench of the timer pair over its register bus
`default_nettype none
module test_gpt_timer_pair;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_mclk = 1'b0;
  logic i_reset = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] v, d0, a0, w0;
  wire [31:0] hrdata, dma_n, adc_n, wot_n;
  wire hready, hresp, irq, dma_a, dma_b, adc_a, adc_b, wot_a, wot_b, pwm_a, pwm_b, ccp_a;
  int num_errors = 0;
  int num_checks = 0;
  initial forever #25 i_mclk = ~i_mclk;
  gpt_timer_pair i_dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp(hresp), .i_ccp_a(ccp_a), .i_ccp_b(1'b0), .o_irq(irq), .o_dma_req_a(dma_a),
    .o_dma_req_b(dma_b), .o_adc_trig_a(adc_a), .o_adc_trig_b(adc_b), .o_wot_trig_a(wot_a),
    .o_wot_trig_b(wot_b), .o_pwm_a(pwm_a), .o_pwm_b(pwm_b));
  gpt_far_side i_far (.i_mclk(i_mclk), .i_dma_a(dma_a), .i_adc_a(adc_a), .i_adc_b(adc_b), .i_wot_a(wot_a),
    .i_wot_b(wot_b), .o_ccp_a(ccp_a), .o_dma_n(dma_n), .o_adc_n(adc_n), .o_wot_n(wot_n));
  task wrap_up;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task hwait;
    int n;
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      chk("bus wait", 0, 1);
      wrap_up;
    end
  endtask
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hwait;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    hwait;
    v = hrdata;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), v, e);
  endtask
  task do_reset;
    i_reset <= 1'b1;
    repeat (5) @(posedge i_mclk);
    i_reset <= 1'b0;
    @(posedge i_mclk);
  endtask
  initial begin
    do_reset;
    rd(8'h10, 32'h0000ffff);
    rd(8'h38, 32'h0);
    rd(8'h7c, 32'h0);
    for (int m = 1; m < 10; m += 8) begin
      bus(1'b1, 8'h04, m);
      bus(1'b1, 8'h28, 32'h1234);
      rd(8'h28, 32'h1234);
    end
    for (int h = 0; h < 2; h++) begin
      a0 = adc_n;
      w0 = wot_n;
      bus(1'b1, 8'(4 + 4 * h), 32'h11);
      bus(1'b1, 8'(24 + 4 * h), 32'h5);
      bus(1'b1, 8'(40 + 4 * h), 32'h5);
      bus(1'b1, 8'h0c, 32'h2 << (8 * h));
      repeat (20) @(posedge i_mclk);
      chk("adc stopped", adc_n - a0, 0);
      chk("chain stopped", wot_n - w0, 0);
      bus(1'b1, 8'(40 + 4 * h), 32'h40);
      bus(1'b1, 8'h0c, 32'h3 << (8 * h));
      repeat (80) @(posedge i_mclk);
      chk("adc run", adc_n - a0, 1);
      chk("chain run", wot_n - w0, 1);
      bus(1'b1, 8'h0c, 32'h0);
      bus(1'b1, 8'(40 + 4 * h), 32'h40);
      bus(1'b1, 8'h0c, 32'h1 << (8 * h));
      repeat (80) @(posedge i_mclk);
      chk("no output trigger", adc_n - a0 + wot_n - w0, 2);
    end
    bus(1'b1, 8'h04, 32'h85);
    bus(1'b1, 8'h10, 32'h20);
    bus(1'b1, 8'h18, 32'h10);
    bus(1'b1, 8'h28, 32'h20);
    bus(1'b1, 8'h0c, 32'h1);
    bus(1'b1, 8'h3c, 32'h3f);
    repeat (100) @(posedge i_mclk);
    bus(1'b0, 8'h3c, 32'h0);
    chk("pwm events", {v[2], v[0]}, 2'b11);
    bus(1'b1, 8'h04, 32'h05);
    bus(1'b1, 8'h3c, 32'h3f);
    repeat (100) @(posedge i_mclk);
    rd(8'h3c, 32'h1);
    chk("masked irq", irq, 0);
    bus(1'b1, 8'h00, 32'h1);
    bus(1'b1, 8'h04, 32'h89);
    bus(1'b1, 8'h10, 32'hffffffff);
    bus(1'b1, 8'h18, 32'h00010010);
    bus(1'b1, 8'h28, 32'h8);
    bus(1'b1, 8'h3c, 32'h3f);
    bus(1'b1, 8'h38, 32'h4);
    d0 = dma_n;
    repeat (40) @(posedge i_mclk);
    rd(8'h3c, 32'h0);
    bus(1'b1, 8'h28, 32'h00010008);
    repeat (40) @(posedge i_mclk);
    rd(8'h3c, 32'h4);
    chk("match irq", irq, 1);
    chk("match dma", dma_n - d0, 1);
    bus(1'b1, 8'h3c, 32'h4);
    repeat (2) @(posedge i_mclk);
    chk("irq cleared", irq, 0);
    bus(1'b1, 8'h04, 32'h181);
    bus(1'b1, 8'h28, 32'h00010004);
    d0 = dma_n;
    repeat (40) @(posedge i_mclk);
    chk("boundary dma", dma_n - d0, 0);
    do_reset;
    bus(1'b1, 8'h10, 32'h3);
    bus(1'b1, 8'h04, 32'h184);
    bus(1'b1, 8'h0c, 32'h1);
    d0 = dma_n;
    repeat (40) @(posedge i_mclk);
    chk("rollover dma", dma_n - d0, 0);
    i_far.pulse;
    bus(1'b0, 8'h3c, 32'h0);
    chk("capture", v[1], 1);
    bus(1'b1, 8'h0c, 32'h0);
    bus(1'b1, 8'h04, 32'h3);
    bus(1'b1, 8'h20, 32'h5a);
    bus(1'b1, 8'h10, 32'h10);
    bus(1'b1, 8'h28, 32'h10);
    bus(1'b1, 8'h0c, 32'h1);
    repeat (3) i_far.pulse;
    rd(8'h30, 32'h005a000d);
    do_reset;
    bus(1'b1, 8'h10, 32'h4);
    bus(1'b1, 8'h28, 32'hfff0);
    bus(1'b1, 8'h20, 32'h1);
    bus(1'b1, 8'h04, 32'h9);
    bus(1'b1, 8'h0c, 32'h1);
    repeat (40) @(posedge i_mclk);
    rd(8'h3c, 32'h1);
    bus(1'b1, 8'h00, 32'h1);
    bus(1'b1, 8'h04, 32'h62);
    bus(1'b1, 8'h28, 32'h00020000);
    i_far.pulse;
    bus(1'b0, 8'h30, 32'h0);
    chk("joined snapshot", v[31:16], 16'h0001);
    wrap_up;
  end
endmodule // test_gpt_timer_pair
`default_nettype wire
